// ---- hpsc_pkg.sv ----
// Shared constants, field positions and mode codes of the host port, straps, clocking, overlay, picture path and test logic.
package hpsc_pkg;
   // Serial packet layout: command byte (read flag, address), then one data byte.
   localparam logic [4:0] CMD_BITS = 5'h08;
   localparam logic [4:0] PKT_BITS = 5'h10;
   localparam logic [4:0] STEP_NARROW = 5'h01;
   localparam logic [4:0] STEP_WIDE = 5'h04;
   localparam int CMD_READ_BIT = 7;
   localparam logic [6:0] ADDR_EVENT_CLEAR = 7'h00;

   // Multi-function bus layout.
   localparam int MFB_WIDTH = 12;
   localparam int STRAP_WIDTH_BIT = 6;
   localparam int STRAP_RESONATOR_DRIVE_OUT_BIT = 5;
   localparam int WIDE_LO_BIT = 7;
   localparam int WIDE_HI_BIT = 9;

   // Clock figures in MHz and the derived reference tick divider.
   localparam int SYS_CLOCK_MHZ = 200;
   localparam int REF_CLOCK_MHZ = 50;
   localparam logic [1:0] REF_DIV_LAST = 2'(SYS_CLOCK_MHZ / REF_CLOCK_MHZ - 1);

   // Widths of the event, overlay, line period and test sections.
   localparam int EVENT_WIDTH = 4;
   localparam int OVERLAY_WIDTH = 4;
   localparam int PERIOD_WIDTH = 16;
   localparam int SCAN_CHAINS = 2;
   localparam int SCAN_LEN = 8;
   localparam logic [15:0] PERIOD_MAX = 16'hffff;

   // Ordered dither thresholds for a two by two pixel cell.
   localparam logic [7:0] DITHER_CELL = 8'h2d;

   typedef enum logic [2:0] {
      HPSC_MODE_NATIVE = 3'h0,
      HPSC_MODE_SLOW_DEST = 3'h1,
      HPSC_MODE_ZOOM = 3'h2,
      HPSC_MODE_DOWNSCALE = 3'h3,
      HPSC_MODE_DEST_ALONE = 3'h4,
      HPSC_MODE_SRC_ALONE = 3'h5
   } hpsc_mode_t;
endpackage

// ---- hpsc_top.sv ----
// Host serial port, reset straps, overlay port, panel clocking and board test logic.
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// [R1] A packet is only the activity seen while host frame sync is high.
// [R2] The host drives the serial clock; the device only receives it.
// [R3] Host data pin is two-way: host writes commands, device returns read data.
// [R4] Reset returns every register to a fixed value; strap, bus pin, write toggle and link reset and width synchroniser registers load from their inputs.
// [R5] Multi-function bus is twelve two-way general pins, bits eleven to zero.
// [R6] Width strap low at reset makes the host port four bits, bus 9:7 upper.
// [R7] Crystal strap low at reset selects the crystal resonator over an oscillator.
// [R8] Reference timing runs from a 50 MHz tick feeding the synthesizers.
// [R9] Overlay controller gets line ref, frame ref, clock; four overlay data inputs.
// [R10] Overlay window select high shows overlay pixels instead of own picture.
// [R11] Board test select high enters assembly test; low means normal operation.
// [R12] Assembly test uses two scan chains, each with one input and output.
// [R13] Source clock recovery is fed the incoming line period in reference ticks.
// [R14] Panel clock is one pixel per clock, half rate for double-pixel panels.
// [R15] A panel rate unlike the source selects the destination synthesizer.
// [R16] Exactly six display modes exist; other codes fall back safely.
// [R17] Eight-bit and six-bit panels are supported, six-bit with dithering.
// [R18] Host port runs one or four data bits wide, picked by strap.
// [R19] Host launches on falling edge; device samples rising, launches rising.
// [R20] Interrupt request stays high until the host clears the event.

// Link-side receiver and transmitter, clocked by the host serial clock.
module hpsc_link (
   // Link clock and reset.
   input wire logic i_host_serial_clock,
   input wire logic i_srst,
   // Host pins.
   input wire logic i_host_frame_sync,
   input wire logic i_host_serial_data,
   input wire logic [2:0] i_host_wide_data_upper,
   output logic o_host_serial_data,
   output logic o_host_serial_data_oe,
   output logic [2:0] o_host_wide_data_upper,
   // System side.
   input wire logic i_wide,
   input wire logic [7:0] i_snapshot,
   output logic o_write_toggle,
   output logic [6:0] o_write_addr,
   output logic [7:0] o_write_data
);
   typedef struct packed {
      logic rst_s1;
      logic rst_s2;
      logic wide_s1;
      logic wide_s2;
      logic [4:0] cnt;
      logic [15:0] shift;
      logic rd;
      logic oe;
      logic [7:0] tx;
      logic tog;
      logic [6:0] waddr;
      logic [7:0] wdata;
   } hpsc_link_t;

   hpsc_link_t r;
   hpsc_link_t next_r;

   always_comb begin
      logic [4:0] step;
      logic [4:0] cnt_new;
      logic [15:0] shift_new;
      step = r.wide_s2 ? hpsc_pkg::STEP_WIDE : hpsc_pkg::STEP_NARROW; // [R18]
      cnt_new = r.cnt + step;
      shift_new = r.wide_s2 ? {r.shift[11:0], i_host_wide_data_upper, i_host_serial_data}
                            : {r.shift[14:0], i_host_serial_data};
      next_r = r;
      next_r.rst_s1 = i_srst;
      next_r.rst_s2 = r.rst_s1;
      next_r.wide_s1 = i_wide;
      next_r.wide_s2 = r.wide_s1;
      if (r.rst_s2) begin
         next_r.cnt = '0;
         next_r.shift = '0;
         next_r.rd = 1'b0;
         next_r.oe = 1'b0;
         next_r.tx = '0;
         next_r.tog = 1'b0;
         next_r.waddr = '0;
         next_r.wdata = '0;
      end else if (!i_host_frame_sync) begin
         // Anything outside the frame is ignored and ends any packet in progress.
         next_r.cnt = '0; // [R1]
         next_r.rd = 1'b0;
         next_r.oe = 1'b0;
      end else if (r.cnt < hpsc_pkg::PKT_BITS) begin
         next_r.cnt = cnt_new;
         if (!r.rd) begin
            next_r.shift = shift_new; // [R19]
            if (cnt_new == hpsc_pkg::CMD_BITS && shift_new[hpsc_pkg::CMD_READ_BIT]) begin
               // Read data goes out on the same rising edge the host sees next fall.
               next_r.rd = 1'b1; // [R3]
               next_r.oe = 1'b1;
               next_r.tx = i_snapshot;
            end
            if (cnt_new == hpsc_pkg::PKT_BITS) begin
               next_r.waddr = shift_new[14:8];
               next_r.wdata = shift_new[7:0];
               next_r.tog = ~r.tog;
            end
         end else begin
            next_r.tx = r.wide_s2 ? {r.tx[3:0], 4'h0} : {r.tx[6:0], 1'b0}; // [R19]
            if (cnt_new == hpsc_pkg::PKT_BITS) begin
               next_r.oe = 1'b0;
            end
         end
      end
   end

   // Only the host clock edge advances this logic; it never drives that clock.
   always_ff @(posedge i_host_serial_clock) begin // [R2]
      r <= next_r;
   end

   assign o_host_serial_data = r.wide_s2 ? r.tx[4] : r.tx[7];
   assign o_host_serial_data_oe = r.oe;
   assign o_host_wide_data_upper = r.tx[7:5];
   assign o_write_toggle = r.tog;
   assign o_write_addr = r.waddr;
   assign o_write_data = r.wdata;
endmodule

module hpsc_top (
   // System clock and reset.
   input wire logic i_clk_sys,
   input wire logic i_srst,
   // Host serial port.
   input wire logic i_host_serial_clock,
   input wire logic i_host_frame_sync,
   input wire logic i_host_serial_data,
   output logic o_host_serial_data,
   output logic o_host_serial_data_oe,
   output logic o_irq,
   // Multi-function bus pins and their general use.
   input wire logic [11:0] i_multi_function_bus,
   output logic [11:0] o_multi_function_bus,
   output logic [11:0] o_multi_function_bus_oe,
   input wire logic [11:0] i_mfb_drive,
   input wire logic [11:0] i_mfb_drive_oe,
   output logic [11:0] o_mfb_sampled,
   // Strap results.
   output logic o_host_wide,
   output logic o_resonator_drive_enable,
   // Host write delivery and events.
   output logic o_write_strobe,
   output logic [6:0] o_write_addr,
   output logic [7:0] o_write_data,
   input wire logic [3:0] i_event,
   // Overlay port.
   input wire logic i_line_sync,
   input wire logic i_frame_sync,
   output logic o_overlay_line_ref,
   output logic o_overlay_frame_ref,
   output logic o_overlay_clock_out,
   input wire logic [3:0] i_overlay_data_in,
   input wire logic i_overlay_window_select,
   // Picture path and panel.
   input wire logic i_pixel_valid,
   input wire logic [23:0] i_pixel_data,
   input wire logic i_panel_six_bit,
   input wire logic i_panel_double_pixel,
   input wire logic [2:0] i_display_mode,
   output logic [23:0] o_panel_pixel,
   output logic o_panel_pixel_valid,
   output logic o_panel_clock_enable,
   output logic o_dest_synth_select,
   output logic [2:0] o_display_mode,
   // Clock recovery.
   input wire logic i_source_hsync,
   output logic [15:0] o_line_period,
   output logic o_line_period_valid,
   // Board test.
   input wire logic i_board_test_select,
   input wire logic [1:0] i_test_chain_input,
   output logic [1:0] o_test_chain_output,
   output logic o_test_mode
);
   typedef struct packed {
      logic [11:0] mfb_s1;
      logic [11:0] mfb_s2;
      logic fsw_s1;
      logic fsw_s2;
      logic [3:0] ovl_s1;
      logic [3:0] ovl_s2;
      logic test_s1;
      logic test_s2;
      logic hs_s1;
      logic hs_s2;
      logic hs_prev;
      logic frm_s1;
      logic frm_s2;
      logic tog_s1;
      logic tog_s2;
      logic tog_seen;
      logic wide;
      logic resonator_drive_out;
      logic [3:0] pending;
      logic [7:0] snap;
      logic [6:0] waddr;
      logic [7:0] wdata;
      logic wstb;
      logic [1:0] ref_div;
      logic [15:0] line_cnt;
      logic [15:0] period;
      logic period_valid;
      logic [2:0] mode;
      logic [23:0] pixel;
      logic pixel_valid;
      logic pix_x;
      logic pix_y;
      logic pclk_phase;
      logic pclk_en;
      logic ovl_clk;
      logic line_ref;
      logic frame_ref;
      logic [15:0] scan;
   } hpsc_sys_t;

   hpsc_sys_t r;
   hpsc_sys_t next_r;
   logic link_tog;
   logic [6:0] link_addr;
   logic [7:0] link_data;
   logic [2:0] link_upper;

   // Expands an overlay colour index: intensity, red, green, blue.
   function automatic logic [23:0] overlay_colour(input logic [3:0] idx);
      logic [7:0] lvl;
      lvl = idx[3] ? 8'hff : 8'h80;
      overlay_colour = {idx[2] ? lvl : 8'h00, idx[1] ? lvl : 8'h00, idx[0] ? lvl : 8'h00};
   endfunction

   // Rounds eight bits to six with a threshold, saturating at full scale.
   function automatic logic [7:0] dither_channel(input logic [7:0] c, input logic [1:0] thr);
      logic [8:0] sum;
      sum = {1'b0, c} + {7'h00, thr};
      dither_channel = sum[8] ? 8'hfc : {sum[7:2], 2'b00};
   endfunction

   hpsc_link u_link (
      .i_host_serial_clock(i_host_serial_clock),
      .i_srst(i_srst),
      .i_host_frame_sync(i_host_frame_sync),
      .i_host_serial_data(i_host_serial_data),
      .i_host_wide_data_upper(i_multi_function_bus[hpsc_pkg::WIDE_HI_BIT:hpsc_pkg::WIDE_LO_BIT]),
      .o_host_serial_data(o_host_serial_data),
      .o_host_serial_data_oe(o_host_serial_data_oe),
      .o_host_wide_data_upper(link_upper),
      .i_wide(r.wide),
      .i_snapshot(r.snap),
      .o_write_toggle(link_tog),
      .o_write_addr(link_addr),
      .o_write_data(link_data)
   );

   always_comb begin
      logic [1:0] thr;
      logic [23:0] src;
      logic [3:0] clear_mask;
      logic ref_tick;
      thr = 2'h0;
      src = '0;
      clear_mask = '0;
      ref_tick = 1'b0;
      next_r = r;
      next_r.mfb_s1 = i_multi_function_bus;
      next_r.mfb_s2 = r.mfb_s1;
      next_r.fsw_s1 = i_overlay_window_select;
      next_r.fsw_s2 = r.fsw_s1;
      next_r.ovl_s1 = i_overlay_data_in;
      next_r.ovl_s2 = r.ovl_s1;
      next_r.test_s1 = i_board_test_select;
      next_r.test_s2 = r.test_s1;
      next_r.hs_s1 = i_source_hsync;
      next_r.hs_s2 = r.hs_s1;
      next_r.hs_prev = r.hs_s2;
      next_r.frm_s1 = i_host_frame_sync;
      next_r.frm_s2 = r.frm_s1;
      next_r.tog_s1 = link_tog;
      next_r.tog_s2 = r.tog_s1;
      next_r.tog_seen = r.tog_s2;
      next_r.wstb = 1'b0;
      next_r.period_valid = 1'b0;

      // A new toggle level means one complete write packet is waiting.
      if (r.tog_s2 != r.tog_seen) begin
         next_r.wstb = 1'b1;
         next_r.waddr = link_addr;
         next_r.wdata = link_data;
         if (link_addr == hpsc_pkg::ADDR_EVENT_CLEAR) begin
            clear_mask = link_data[3:0];
         end
      end
      // An event arriving with its clear still sets the flag.
      next_r.pending = (r.pending & ~clear_mask) | i_event; // [R20]

      // The read image is frozen for the whole frame so the link sees stable bits.
      if (!r.frm_s2) begin
         next_r.snap = {r.pending, r.test_s2, r.resonator_drive_out, r.wide, 1'b0};
      end

      // Reference tick at the reference clock rate.
      ref_tick = (r.ref_div == hpsc_pkg::REF_DIV_LAST); // [R8]
      next_r.ref_div = ref_tick ? 2'h0 : r.ref_div + 2'h1;
      if (r.hs_s2 && !r.hs_prev) begin
         next_r.period = r.line_cnt; // [R13]
         next_r.period_valid = 1'b1;
         // The tick of the edge cycle opens the next line, so the period does not depend on tick phase.
         next_r.line_cnt = ref_tick ? 16'h0001 : 16'h0000;
      end else if (ref_tick && r.line_cnt != hpsc_pkg::PERIOD_MAX) begin
         next_r.line_cnt = r.line_cnt + 16'h0001;
      end

      // Unknown codes fall back to destination stand alone, which is always stable.
      if (i_display_mode > 3'(hpsc_pkg::HPSC_MODE_SRC_ALONE)) begin // [R16]
         next_r.mode = hpsc_pkg::HPSC_MODE_DEST_ALONE;
      end else begin
         next_r.mode = i_display_mode;
      end

      // Overlay timing references and a half rate overlay clock.
      next_r.line_ref = i_line_sync; // [R9]
      next_r.frame_ref = i_frame_sync;
      next_r.ovl_clk = ~r.ovl_clk;

      // Picture path with overlay mux and optional six bit dither.
      src = r.fsw_s2 ? overlay_colour(r.ovl_s2) : i_pixel_data; // [R10]
      thr = r.pix_y ? hpsc_pkg::DITHER_CELL[{1'b1, r.pix_x, 1'b0} +: 2]
                    : hpsc_pkg::DITHER_CELL[{1'b0, r.pix_x, 1'b0} +: 2];
      next_r.pixel_valid = i_pixel_valid;
      if (i_pixel_valid) begin
         next_r.pix_x = ~r.pix_x;
         if (i_panel_six_bit) begin
            next_r.pixel = {dither_channel(src[23:16], thr), dither_channel(src[15:8], thr),
                            dither_channel(src[7:0], thr)}; // [R17]
         end else begin
            next_r.pixel = src;
         end
         next_r.pclk_phase = ~r.pclk_phase;
      end
      if (i_line_sync) begin
         next_r.pix_x = 1'b0;
         next_r.pix_y = ~r.pix_y;
      end
      next_r.pclk_en = i_pixel_valid && (!i_panel_double_pixel || r.pclk_phase); // [R14]

      // Scan chains shift only in assembly test mode.
      if (r.test_s2) begin // [R11]
         next_r.scan = {r.scan[14:8], i_test_chain_input[1], r.scan[6:0], i_test_chain_input[0]}; // [R12]
      end

      if (i_srst) begin
         next_r = '0; // [R4]
         next_r.mfb_s1 = i_multi_function_bus;
         next_r.mfb_s2 = r.mfb_s1;
         next_r.tog_s1 = link_tog;
         next_r.tog_s2 = r.tog_s1;
         next_r.tog_seen = r.tog_s2;
         // Straps are caught on clock edges while reset is held; the last one stays.
         next_r.wide = ~r.mfb_s2[hpsc_pkg::STRAP_WIDTH_BIT]; // [R6]
         next_r.resonator_drive_out = ~r.mfb_s2[hpsc_pkg::STRAP_RESONATOR_DRIVE_OUT_BIT]; // [R7]
      end
   end

   always_ff @(posedge i_clk_sys) begin
      r <= next_r;
   end

   // Bus pins: released during reset, except 9:7 in wide mode, so the straps can be read; wide mode lends 9:7 to the host port.
   always_comb begin
      o_multi_function_bus = i_mfb_drive; // [R5]
      o_multi_function_bus_oe = i_srst ? 12'h000 : i_mfb_drive_oe;
      if (r.wide) begin
         o_multi_function_bus[hpsc_pkg::WIDE_HI_BIT:hpsc_pkg::WIDE_LO_BIT] = link_upper; // [R6]
         o_multi_function_bus_oe[hpsc_pkg::WIDE_HI_BIT:hpsc_pkg::WIDE_LO_BIT] = {3{o_host_serial_data_oe}};
      end
   end

   assign o_mfb_sampled = r.mfb_s2;
   assign o_irq = |r.pending; // [R20]
   assign o_host_wide = r.wide;
   assign o_resonator_drive_enable = r.resonator_drive_out; // [R7]
   assign o_write_strobe = r.wstb;
   assign o_write_addr = r.waddr;
   assign o_write_data = r.wdata;
   assign o_overlay_line_ref = r.line_ref;
   assign o_overlay_frame_ref = r.frame_ref;
   assign o_overlay_clock_out = r.ovl_clk;
   assign o_panel_pixel = r.pixel;
   assign o_panel_pixel_valid = r.pixel_valid;
   assign o_panel_clock_enable = r.pclk_en;
   assign o_dest_synth_select = (r.mode != hpsc_pkg::HPSC_MODE_NATIVE); // [R15]
   assign o_display_mode = r.mode;
   assign o_line_period = r.period;
   assign o_line_period_valid = r.period_valid;
   assign o_test_chain_output = {r.scan[15], r.scan[7]}; // [R12]
   assign o_test_mode = r.test_s2;
endmodule
`default_nettype wire

// ---- hpsc_props.sv ----
// Concurrent checks on the host port, straps, overlay, modes and test logic.
`timescale 1ns/10ps
`default_nettype none
module hpsc_props (
   // Clock and reset.
   input wire logic i_clk_sys,
   input wire logic i_srst,
   // Host port, events and pins.
   input wire logic o_host_serial_data_oe,
   input wire logic o_irq,
   input wire logic [11:0] o_multi_function_bus_oe,
   input wire logic [11:0] i_mfb_drive_oe,
   input wire logic o_host_wide,
   input wire logic o_write_strobe,
   input wire logic [3:0] i_event,
   // Overlay, picture and test.
   input wire logic i_line_sync,
   input wire logic i_frame_sync,
   input wire logic o_overlay_line_ref,
   input wire logic o_overlay_frame_ref,
   input wire logic o_overlay_clock_out,
   input wire logic i_pixel_valid,
   input wire logic o_panel_pixel_valid,
   input wire logic [2:0] i_display_mode,
   input wire logic [2:0] o_display_mode,
   input wire logic o_dest_synth_select,
   input wire logic i_board_test_select,
   input wire logic o_test_mode
);
   default clocking cb @(posedge i_clk_sys);
   endclocking
   default disable iff (i_srst);
   sequence s_event_hit;
      |i_event;
   endsequence
   sequence s_test_raised;
      $rose(i_board_test_select);
   endsequence
   // Pins must float while reset is high, so this one is not disabled by it.
   AST_OE_IN_RESET: assert property (disable iff (1'b0) i_srst |-> o_multi_function_bus_oe == 12'h000)
      else $error("pin drive enabled in reset");
   AST_GEN_OE: assert property (!o_host_wide |-> o_multi_function_bus_oe == i_mfb_drive_oe)
      else $error("general pin enable mismatch");
   AST_WIDE_PINS: assert property (o_host_wide |-> o_multi_function_bus_oe[9:7] == {3{o_host_serial_data_oe}})
      else $error("wide data pins not following link drive");
   AST_IRQ_SET: assert property (s_event_hit |-> ##[1:2] o_irq)
      else $error("event did not raise irq");
   AST_IRQ_HOLD: assert property ($fell(o_irq) |-> o_write_strobe || $past(o_write_strobe) || $past(o_write_strobe, 2))
      else $error("irq dropped without host clear");
   AST_STROBE_PULSE: assert property (o_write_strobe |=> !o_write_strobe)
      else $error("write strobe longer than one cycle");
   AST_OVL_REFS: assert property (!$past(i_srst) |-> o_overlay_line_ref == $past(i_line_sync) && o_overlay_frame_ref == $past(i_frame_sync))
      else $error("overlay refs not one cycle behind");
   AST_OVL_CLOCK: assert property (!$past(i_srst) |-> o_overlay_clock_out != $past(o_overlay_clock_out))
      else $error("overlay clock did not toggle");
   AST_PIXEL_VALID: assert property (!$past(i_srst) |-> o_panel_pixel_valid == $past(i_pixel_valid))
      else $error("panel valid latency wrong");
   AST_MODE_MAP: assert property (!$past(i_srst) |-> o_display_mode == (($past(i_display_mode) > hpsc_pkg::HPSC_MODE_SRC_ALONE) ? hpsc_pkg::HPSC_MODE_DEST_ALONE : $past(i_display_mode)))
      else $error("display mode mapping wrong");
   AST_DEST_SEL: assert property (o_dest_synth_select == (o_display_mode != hpsc_pkg::HPSC_MODE_NATIVE))
      else $error("destination synth select wrong");
   AST_TEST_MODE: assert property (s_test_raised |-> ##[1:4] o_test_mode)
      else $error("test mode not entered");
endmodule
bind hpsc_top hpsc_props hpsc_props_inst (
   .i_clk_sys, .i_srst, .o_host_serial_data_oe, .o_irq, .o_multi_function_bus_oe, .i_mfb_drive_oe,
   .o_host_wide, .o_write_strobe, .i_event, .i_line_sync, .i_frame_sync, .o_overlay_line_ref,
   .o_overlay_frame_ref, .o_overlay_clock_out, .i_pixel_valid, .o_panel_pixel_valid, .i_display_mode,
   .o_display_mode, .o_dest_synth_select, .i_board_test_select, .o_test_mode
);
`default_nettype wire

// ---- hpsc_host_model.sv ----
// Behavioural host controller driving the serial host port.
`timescale 1ns/10ps
`default_nettype none
module hpsc_host_model (
   // Link pins driven by the host.
   output logic o_clk,
   output logic o_fs,
   output logic [3:0] o_pins,
   // Resolved data lines seen by the host.
   input wire logic [3:0] i_line
);
   initial begin
      o_clk = 1'b0;
      o_fs = 1'b0;
      o_pins = 4'h0;
   end
   // Clock pulses with frame low; they flush the link and clock its reset.
   task automatic idle(input int n);
      repeat (n) begin
         #3 o_clk = 1'b1;
         #3 o_clk = 1'b0;
      end
   endtask
   // The clock only runs inside the frame plus one closing edge.
   task automatic xfer(input logic wide, input logic [15:0] pkt, output logic [7:0] rd);
      int n;
      logic [15:0] v;
      n = wide ? 4 : 16;
      rd = 8'h00;
      o_fs = 1'b1;
      for (int i = 0; i < n; i++) begin
         v = pkt >> (16 - (16 / n) * (i + 1));
         if (i < n / 2 || !pkt[15])
            o_pins = wide ? v[3:0] : {o_pins[3:1], v[0]};
         else
            o_pins = ~o_pins;
         #3 o_clk = 1'b1;
         #3 o_clk = 1'b0;
         if (pkt[15] && i >= n / 2 - 1 && i < n - 1)
            rd = wide ? {rd[3:0], i_line} : {rd[6:0], i_line[0]};
      end
      o_fs = 1'b0;
      o_pins = ~o_pins;
      idle(1);
   endtask
endmodule
`default_nettype wire

// ---- testbench.sv ----
// Self-checking bench for the host port, straps, overlay, modes and test logic.
`timescale 1ns/10ps
`default_nettype none
module testbench;
   logic i_clk_sys = 1'b0, i_srst = 1'b1, i_line_sync = 1'b0, i_frame_sync = 1'b0, i_overlay_window_select = 1'b0;
   logic i_pixel_valid = 1'b0, i_panel_six_bit = 1'b0, i_panel_double_pixel = 1'b0, i_source_hsync = 1'b0;
   logic i_board_test_select = 1'b0, wide_cfg = 1'b0, pe;
   logic [1:0] i_test_chain_input = 2'h0;
   logic [2:0] i_display_mode = 3'h0;
   logic [3:0] i_event = 4'h0, i_overlay_data_in = 4'h0, hpins, hline;
   logic [11:0] i_mfb_drive = 12'h000, i_mfb_drive_oe = 12'h000, pin_drv = 12'hfff, i_multi_function_bus;
   logic [23:0] i_pixel_data = 24'h000000;
   logic i_host_serial_clock, i_host_frame_sync, i_host_serial_data, o_host_serial_data, o_host_serial_data_oe;
   logic o_irq, o_host_wide, o_resonator_drive_enable, o_write_strobe, o_overlay_line_ref, o_overlay_frame_ref;
   logic o_overlay_clock_out, o_panel_pixel_valid, o_dest_synth_select, o_test_mode;
   logic o_panel_clock_enable, o_line_period_valid;
   logic [1:0] o_test_chain_output;
   logic [2:0] o_display_mode;
   logic [6:0] o_write_addr;
   logic [7:0] o_write_data, rd;
   logic [11:0] o_multi_function_bus, o_multi_function_bus_oe, o_mfb_sampled;
   logic [15:0] o_line_period;
   logic [23:0] o_panel_pixel;
   int errors = 0, num_checks = 0;
   always #2.5 i_clk_sys = ~i_clk_sys;
   // Straps and external pins have pull-ups; the device wins wherever it drives.
   assign i_multi_function_bus = (o_multi_function_bus & o_multi_function_bus_oe)
      | ({pin_drv[11:10], wide_cfg ? hpins[3:1] : pin_drv[9:7], pin_drv[6:0]} & ~o_multi_function_bus_oe);
   assign i_host_serial_data = o_host_serial_data_oe ? o_host_serial_data : hpins[0];
   assign hline = {i_multi_function_bus[9:7], i_host_serial_data};
   hpsc_host_model hpsc_host_model_inst (
      .o_clk(i_host_serial_clock), .o_fs(i_host_frame_sync), .o_pins(hpins), .i_line(hline)
   );
   hpsc_top hpsc_top_inst (
      .i_clk_sys, .i_srst, .i_host_serial_clock, .i_host_frame_sync, .i_host_serial_data, .o_host_serial_data,
      .o_host_serial_data_oe, .o_irq, .i_multi_function_bus, .o_multi_function_bus, .o_multi_function_bus_oe,
      .i_mfb_drive, .i_mfb_drive_oe, .o_mfb_sampled, .o_host_wide, .o_resonator_drive_enable, .o_write_strobe,
      .o_write_addr, .o_write_data, .i_event, .i_line_sync, .i_frame_sync, .o_overlay_line_ref,
      .o_overlay_frame_ref, .o_overlay_clock_out, .i_overlay_data_in, .i_overlay_window_select, .i_pixel_valid,
      .i_pixel_data, .i_panel_six_bit, .i_panel_double_pixel, .i_display_mode, .o_panel_pixel,
      .o_panel_pixel_valid, .o_panel_clock_enable, .o_dest_synth_select, .o_display_mode, .i_source_hsync,
      .o_line_period, .o_line_period_valid, .i_board_test_select, .i_test_chain_input, .o_test_chain_output,
      .o_test_mode
   );
   task automatic tick(input int n);
      repeat (n) @(posedge i_clk_sys);
      #1;
   endtask
   task automatic check(input logic [23:0] got, input logic [23:0] exp);
      num_checks++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic finish_test();
      $display("Checks %0d, errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic host_write(input logic [6:0] a, input logic [7:0] d);
      logic seen;
      seen = 1'b0;
      fork
         hpsc_host_model_inst.xfer(wide_cfg, {1'b0, a, d}, rd);
         repeat (60) begin
            tick(1);
            if (o_write_strobe === 1'b1 && !seen) begin
               seen = 1'b1;
               check(24'({o_write_addr, o_write_data}), 24'({a, d}));
            end
         end
      join
      check(24'(seen), 24'h1);
   endtask
   task automatic host_read(input logic [7:0] exp);
      hpsc_host_model_inst.xfer(wide_cfg, 16'h8000, rd);
      check(24'(rd), 24'(exp));
   endtask
   task automatic reset_run();
      i_srst = 1'b1;
      fork
         hpsc_host_model_inst.idle(12);
         tick(20);
      join
      i_srst = 1'b0;
      // The link's reset synchroniser only moves on host clock edges, so flush it with frame low.
      hpsc_host_model_inst.idle(3);
   endtask
   initial begin
      reset_run();
      tick(4);
      check(24'({o_host_wide, o_resonator_drive_enable, o_irq}), 24'h0);
      host_write(7'h15, 8'ha6);
      i_event = 4'h5;
      tick(1);
      i_event = 4'h0;
      tick(4);
      check(24'(o_irq), 24'h1);
      host_read(8'h50);
      host_write(7'h00, 8'h04);
      tick(4);
      host_read(8'h10);
      check(24'(o_irq), 24'h1);
      host_write(7'h00, 8'h01);
      tick(4);
      check(24'(o_irq), 24'h0);
      i_mfb_drive = 12'ha5c;
      i_mfb_drive_oe = 12'h0f0;
      pin_drv = 12'h3c3;
      tick(4);
      check(24'({o_multi_function_bus_oe, o_mfb_sampled}), 24'h0f0353);
      i_mfb_drive_oe = 12'h000;
      pin_drv = 12'hfff;
      i_board_test_select = 1'b1;
      i_test_chain_input = 2'h2;
      tick(16);
      check(24'({o_test_mode, o_test_chain_output}), 24'h6);
      host_read(8'h08);
      i_board_test_select = 1'b0;
      for (int m = 0; m < 8; m++) begin
         i_display_mode = 3'(m);
         tick(2);
         check(24'({o_dest_synth_select, o_display_mode}), 24'(m > 5 ? 12 : m == 0 ? 0 : 8 + m));
      end
      i_display_mode = 3'h0;
      i_pixel_valid = 1'b1;
      i_pixel_data = 24'h123456;
      i_overlay_data_in = 4'h7;
      i_overlay_window_select = 1'b1;
      i_line_sync = 1'b1;
      i_frame_sync = 1'b1;
      tick(6);
      check(o_panel_pixel, 24'h808080);
      i_overlay_window_select = 1'b0;
      i_line_sync = 1'b0;
      tick(6);
      check(o_panel_pixel, 24'h123456);
      i_panel_six_bit = 1'b1;
      tick(4);
      check(o_panel_pixel & 24'h030303, 24'h000000);
      i_panel_double_pixel = 1'b1;
      tick(2);
      pe = o_panel_clock_enable;
      tick(1);
      check(24'(pe ^ o_panel_clock_enable), 24'h1);
      i_pixel_valid = 1'b0;
      i_frame_sync = 1'b0;
      // Edges 400 cycles apart are exactly 100 ticks of the 50 MHz reference.
      for (int k = 0; k < 3; k++) begin
         i_source_hsync = 1'b1;
         tick(3);
         check(24'(o_line_period_valid), 24'h1);
         tick(5);
         i_source_hsync = 1'b0;
         tick(392);
      end
      check(24'(o_line_period), 24'h000064);
      i_event = 4'h2;
      tick(1);
      i_event = 4'h0;
      pin_drv = 12'hf9f;
      reset_run();
      wide_cfg = 1'b1;
      pin_drv = 12'hfff;
      tick(4);
      check(24'({o_host_wide, o_resonator_drive_enable, o_irq}), 24'h6);
      host_write(7'h2a, 8'h5c);
      host_read(8'h06);
      tick(4);
      finish_test();
   end
   // The sequence needs under 10 us; twice that means a hang.
   initial begin
      #20000;
      errors++;
      finish_test();
   end
endmodule
`default_nettype wire
